// ===== design/ptac_slot.sv
// ptac_slot: one outstanding read request with its completion timer.
// assumes tick is a one-cycle enable and ack only comes while due.
`timescale 1ns/100ps
module ptac_slot import ptac_pkg::*; #(
   parameter int unsigned TW = 26,
   parameter int unsigned CW = 4,
   parameter int unsigned RW = 2
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // request side
   input wire logic start,
   input wire logic [CW-1:0] cplCnt,
   input wire logic cplHit,
   // timer control
   input wire logic tick,
   input wire logic [TW-1:0] limit,
   input wire logic ctoOn,
   input wire logic resendOn,
   input wire logic [RW-1:0] resendMax,
   input wire logic ack,
   // state
   output logic busy,
   output logic due,
   output logic retryOk
);
   ptac_slot_e st_q;
   logic [CW-1:0] left_q;
   logic [CW-1:0] orig_q;
   logic [TW-1:0] tmr_q;
   logic [RW-1:0] tries_q;
   wire logic [CW-1:0] cntFix = (cplCnt == '0) ? CW'(1) : cplCnt;
   wire logic expire = (tmr_q + TW'(1)) >= limit;

   assign busy = (st_q != SL_IDLE);
   assign due = (st_q == SL_DUE);
   assign retryOk = resendOn && ctoOn && (tries_q < resendMax);

   // ==========================================================
   // slot sequence
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= SL_IDLE;
         left_q <= '0;
         orig_q <= '0;
         tmr_q <= '0;
         tries_q <= '0;
      end else begin
         unique case (st_q)
            SL_IDLE: if (start) begin
               st_q <= SL_WAIT;
               left_q <= cntFix;
               orig_q <= cntFix;
               tmr_q <= '0;
               tries_q <= '0;
            end
            SL_WAIT: if (cplHit) begin
               // done only on the last of its completions
               if (left_q == CW'(1)) st_q <= SL_IDLE;
               left_q <= left_q - CW'(1);
            end else if (ctoOn && tick) begin
               if (expire) st_q <= SL_DUE;
               tmr_q <= tmr_q + TW'(1);
            end
            // served timeout beats a completion in the same cycle,
            // so a reported event never refers to a finished read
            SL_DUE: if (ack) begin
               if (retryOk) begin
                  st_q <= SL_WAIT;
                  left_q <= orig_q;
                  tmr_q <= '0;
                  tries_q <= tries_q + RW'(1);
               end else begin
                  st_q <= SL_IDLE;
               end
            end else if (cplHit) begin
               if (left_q == CW'(1)) st_q <= SL_IDLE;
               left_q <= left_q - CW'(1);
            end
            default: st_q <= SL_IDLE;
         endcase
      end
   end
endmodule : ptac_slot

// ===== design/ptac_tag_cto.sv
// ptac_tag_cto: request tag allocation and completion timeout.
// assumes same-clock request/completion strobes from the transaction
// layer; link pins and the nvm strap are asynchronous to mclk.
//
// How it works
// - one function, device number from config write
// - messages always carry tag zero
// - data reads use tags zero to five
// - descriptor reads 0x18/0x1C; completions routed by tag
// - steering off: fixed write tags per source
// - legacy mode, request unsteered: same fixed tags
// - version-one mode, request unsteered: tag zero
// - version-one mode: messages, msi use no-hint tag
// - legacy steered: flag bit 0, cpu bits 2:0 in tag bits 3:1
// - version-one steered: tag is full cpu id
// - hints on everywhere: tag is full cpu id for tx/rx write-back and rx payload with their hint bit set
// - timer starts when a read is sent
// - timeout on from reset, software may disable
// - timeout period chosen by software range code
// - resend enable from nvm, default on
// - resend count limit field, resets to three
// - single lane 2.5 Gb/s 8b/10b link
// - multi-completion read ends on last completion
`timescale 1ns/100ps
`include "ptac_cfg.svh"
module ptac_tag_cto import ptac_pkg::*; #(
   parameter int unsigned TICK_CYC = `PTAC_TICK_NS / `PTAC_CLK_NS,
   parameter int unsigned NDATA = 6
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // link side pins and strap
   input wire logic lnkClk,
   input wire logic lnkCfgWr,
   input wire logic [4:0] lnkDevNum,
   input wire logic nvmResendEn,
   // read requests
   input wire logic rdReq,
   input wire logic [2:0] rdClient,
   input wire logic [3:0] rdCplCnt,
   output logic [7:0] rdFree,
   output logic [7:0] rdTag,
   output logic rdTagValid,
   // write and message requests
   input wire logic wrReq,
   input wire ptac_src_e wrSrc,
   output logic [7:0] wrTag,
   output logic wrTagValid,
   // completions
   input wire logic cplValid,
   input wire logic [7:0] cplTag,
   // timeout reactions
   output logic resendValid,
   output logic [7:0] resendTag,
   output logic ctoErr,
   output logic [7:0] ctoErrTag
);
   localparam int unsigned NSLOT = NDATA + 2;
   localparam int unsigned TKW = $clog2(TICK_CYC + 1);

   // ==========================================================
   // registers
   logic [2:0] ctrl_q;
   logic [12:0] txSteer_q;
   logic [12:0] rxSteer_q;
   logic [4:0] devCtl2_q;
   logic resendEn_q;
   logic [1:0] resendMax_q;
   logic [4:0] devNum_q;
   logic [7:0] errCnt_q;
   logic [1:0] ldCnt_q;
   logic nvmS1_q;
   logic nvmS2_q;
   logic [TKW-1:0] tickCnt_q;
   logic tick_q;

   wire logic hitCtrl = regAddr == `PTAC_REG_CTRL;
   wire logic hitTx = regAddr == `PTAC_REG_TXSTEER;
   wire logic hitRx = regAddr == `PTAC_REG_RXSTEER;
   wire logic hitDc2 = regAddr == `PTAC_REG_DEVCTL2;
   wire logic hitGen = regAddr == `PTAC_REG_GENCTL;
   wire logic hitStat = regAddr == `PTAC_REG_STATUS;

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_q <= `PTAC_CTRL_RST;
         txSteer_q <= '0;
         rxSteer_q <= '0;
         devCtl2_q <= '0; // timeout enabled out of reset
         resendMax_q <= `PTAC_RSND_CNT_RST;
      end else if (regWr) begin
         if (hitCtrl) ctrl_q <= regWdata[2:0];
         if (hitTx) txSteer_q <= {3'h0, regWdata[9:0]};
         if (hitRx) rxSteer_q <= regWdata[12:0];
         if (hitDc2) devCtl2_q <= regWdata[4:0];
         if (hitGen) resendMax_q <= regWdata[2:1];
      end
   end

   // ==========================================================
   // resend enable: defaults on, then the nvm strap after reset
   // three-edge load delay lets the strap pass its synchroniser
   always_ff @(posedge mclk) begin
      if (rst) begin
         nvmS1_q <= 1'b0;
         nvmS2_q <= 1'b0;
         ldCnt_q <= 2'h3;
         resendEn_q <= 1'b1;
      end else begin
         nvmS1_q <= nvmResendEn;
         nvmS2_q <= nvmS1_q;
         if (ldCnt_q != 2'h0) ldCnt_q <= ldCnt_q - 2'h1;
         if (ldCnt_q == 2'h1) resendEn_q <= nvmS2_q;
         else if (regWr && hitGen) resendEn_q <= regWdata[`PTAC_GEN_RSND];
      end
   end

   // ==========================================================
   // link pins: mclk samples the slow link clock and its strobes
   // the serial lane itself lives in the phy; only the captured
   // configuration write reaches this block
   logic [6:0] lnkS1_q;
   logic [6:0] lnkS2_q;
   logic lnkClkD_q;
   wire logic lnkRise = lnkS2_q[6] && !lnkClkD_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         lnkS1_q <= '0;
         lnkS2_q <= '0;
         lnkClkD_q <= 1'b0;
         devNum_q <= '0;
      end else begin
         lnkS1_q <= {lnkClk, lnkCfgWr, lnkDevNum};
         lnkS2_q <= lnkS1_q;
         lnkClkD_q <= lnkS2_q[6];
         if (lnkRise && lnkS2_q[5]) devNum_q <= lnkS2_q[4:0];
      end
   end

   // ==========================================================
   // microsecond tick for the timers
   always_ff @(posedge mclk) begin
      if (rst) begin
         tickCnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= tickCnt_q == TKW'(TICK_CYC - 1);
         if (tickCnt_q == TKW'(TICK_CYC - 1)) tickCnt_q <= '0;
         else tickCnt_q <= tickCnt_q + TKW'(1);
      end
   end

   // ==========================================================
   // timeout period from the range code; unknown codes fall back
   // to the default range
   function automatic logic [25:0] ctoLimit(input logic [3:0] code);
      unique case (code)
         4'h1: ctoLimit = `PTAC_CTO_R1_US;
         4'h2: ctoLimit = `PTAC_CTO_R2_US;
         4'h5: ctoLimit = `PTAC_CTO_R5_US;
         4'h6: ctoLimit = `PTAC_CTO_R6_US;
         4'h9: ctoLimit = `PTAC_CTO_R9_US;
         4'hA: ctoLimit = `PTAC_CTO_RA_US;
         4'hD: ctoLimit = `PTAC_CTO_RD_US;
         4'hE: ctoLimit = `PTAC_CTO_RE_US;
         default: ctoLimit = `PTAC_CTO_R0_US;
      endcase
   endfunction : ctoLimit

   wire logic [25:0] limit = ctoLimit(devCtl2_q[3:0]);
   wire logic ctoOn = !devCtl2_q[`PTAC_DC2_DIS];

   // ==========================================================
   // read slots, one per read tag
   wire logic [NSLOT-1:0] busy;
   wire logic [NSLOT-1:0] due;
   wire logic [NSLOT-1:0] retryOk;
   wire logic [NSLOT-1:0] cplHit;
   wire logic [NSLOT-1:0] startVec;
   logic [NSLOT-1:0] ackVec;
   wire logic [7:0] slotTag [NSLOT];

   wire logic rdTake = rdReq && !busy[rdClient];
   assign ackVec = due & (~due + NSLOT'(1));

   for (genvar i = 0; i < NSLOT; i++) begin : g_slot
      // data slots tag by index, the last two are descriptors
      assign slotTag[i] = (i < NDATA) ? 8'(i) :
         (i == NDATA) ? `PTAC_TAG_TXDESC : `PTAC_TAG_RXDESC;
      // the partner echoes the request tag
      assign cplHit[i] = cplValid && (cplTag == slotTag[i]);
      assign startVec[i] = rdTake && (rdClient == 3'(i));
      ptac_slot #(.TW(26), .CW(4), .RW(2)) u_slot (
         .mclk(mclk),
         .rst(rst),
         .start(startVec[i]),
         .cplCnt(rdCplCnt),
         .cplHit(cplHit[i]),
         .tick(tick_q),
         .limit(limit),
         .ctoOn(ctoOn),
         .resendOn(resendEn_q),
         .resendMax(resendMax_q),
         .ack(ackVec[i]),
         .busy(busy[i]),
         .due(due[i]),
         .retryOk(retryOk[i])
      );
   end

   // one-hot pick to tag and retry decision
   logic [7:0] ackTag;
   logic ackRetry;
   always_comb begin
      ackTag = 8'h00;
      ackRetry = 1'b0;
      for (int i = 0; i < NSLOT; i++) begin
         if (ackVec[i]) begin
            ackTag = slotTag[i];
            ackRetry = retryOk[i];
         end
      end
   end

   // ==========================================================
   // write and message tag selection
   wire logic isTxWb = wrSrc == SRC_TXWB;
   wire logic isRxWb = wrSrc == SRC_RXWB;
   wire logic isRxHdr = wrSrc == SRC_RXHDR;
   wire logic isRxPay = wrSrc == SRC_RXPAY;
   wire logic isMsi = wrSrc == SRC_MSI;
   wire logic isMsg = wrSrc == SRC_MSG;
   wire logic sysDis = ctrl_q[`PTAC_CTRL_SYSDIS];
   wire logic modeV1 = ctrl_q[`PTAC_CTRL_V1];
   wire logic tphSys = ctrl_q[`PTAC_CTRL_TPHSYS];
   wire logic steerEn = (isTxWb && txSteer_q[`PTAC_TX_DSTEER])
      || (isRxWb && rxSteer_q[`PTAC_RX_DSTEER])
      || (isRxHdr && rxSteer_q[`PTAC_RX_HSTEER])
      || (isRxPay && rxSteer_q[`PTAC_RX_PSTEER]);
   wire logic tphEn = (isTxWb && txSteer_q[`PTAC_TX_DTPH])
      || (isRxWb && rxSteer_q[`PTAC_RX_DTPH])
      || (isRxPay && rxSteer_q[`PTAC_RX_PTPH]);
   wire logic [7:0] target_cpu_identifier = isTxWb ? txSteer_q[7:0] : rxSteer_q[7:0];
   wire logic [7:0] baseTag = isTxWb ? `PTAC_TAG_TXWB :
      isRxWb ? `PTAC_TAG_RXWB :
      isMsi ? `PTAC_TAG_MSI : `PTAC_TAG_DATA;
   wire logic [7:0] legTag = {4'h0, target_cpu_identifier[2:0], 1'b1};
   wire logic [7:0] v1Tag = isMsi ? `PTAC_TAG_NOHINT :
      steerEn ? target_cpu_identifier : `PTAC_TAG_V1OFF;
   wire logic [7:0] wrTagD = isMsg ? `PTAC_TAG_MSG :
      (tphSys && tphEn) ? target_cpu_identifier :
      sysDis ? baseTag :
      !modeV1 ? (steerEn ? legTag : baseTag) : v1Tag;

   // ==========================================================
   // request and timeout outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdFree <= '0;
         rdTag <= 8'h00;
         rdTagValid <= 1'b0;
         wrTag <= 8'h00;
         wrTagValid <= 1'b0;
         resendValid <= 1'b0;
         resendTag <= 8'h00;
         ctoErr <= 1'b0;
         ctoErrTag <= 8'h00;
         errCnt_q <= 8'h00;
      end else begin
         rdFree <= ~busy;
         rdTagValid <= rdTake;
         if (rdTake) rdTag <= slotTag[rdClient];
         wrTagValid <= wrReq;
         if (wrReq) wrTag <= wrTagD;
         resendValid <= |due && ackRetry;
         ctoErr <= |due && !ackRetry;
         if (|due && ackRetry) resendTag <= ackTag;
         if (|due && !ackRetry) begin
            ctoErrTag <= ackTag;
            errCnt_q <= errCnt_q + 8'h01;
         end
      end
   end

   // ==========================================================
   // register read, data one cycle after the strobe
   wire logic [31:0] statWord = {errCnt_q, NSLOT'(due), NSLOT'(busy),
      3'h0, devNum_q};
   wire logic [31:0] rdMux =
      hitCtrl ? {29'h0, ctrl_q} :
      hitTx ? {19'h0, txSteer_q} :
      hitRx ? {19'h0, rxSteer_q} :
      hitDc2 ? {27'h0, devCtl2_q} :
      hitGen ? {29'h0, resendMax_q, resendEn_q} :
      hitStat ? statWord : 32'h0;

   always_ff @(posedge mclk) begin
      if (rst) regRdata <= 32'h0;
      else if (regRd) regRdata <= rdMux;
      else regRdata <= 32'h0;
   end
endmodule : ptac_tag_cto

// ===== shared/ptac_cfg.svh
// ptac_cfg.svh: offsets, field positions, reset values, tags, timing.
// assumes a 100 MHz core clock; included by its bare name.
`ifndef PTAC_CFG_SVH
`define PTAC_CFG_SVH
// ==========================================================
// clock and timing
`define PTAC_CLK_NS 10
`define PTAC_TICK_NS 1000
`define PTAC_CTO_R0_US 26'h000C350
`define PTAC_CTO_R1_US 26'h0000064
`define PTAC_CTO_R2_US 26'h0002710
`define PTAC_CTO_R5_US 26'h000D6D8
`define PTAC_CTO_R6_US 26'h0033450
`define PTAC_CTO_R9_US 26'h00DBBA0
`define PTAC_CTO_RA_US 26'h0356820
`define PTAC_CTO_RD_US 26'h0C65D40
`define PTAC_CTO_RE_US 26'h3D09000
// ==========================================================
// register offsets
`define PTAC_REG_CTRL 8'h00
`define PTAC_REG_TXSTEER 8'h04
`define PTAC_REG_RXSTEER 8'h08
`define PTAC_REG_DEVCTL2 8'h0C
`define PTAC_REG_GENCTL 8'h10
`define PTAC_REG_STATUS 8'h14
// ==========================================================
// field positions and reset values
`define PTAC_CTRL_SYSDIS 0
`define PTAC_CTRL_V1 1
`define PTAC_CTRL_TPHSYS 2
`define PTAC_CTRL_RST 3'h1
`define PTAC_TX_DSTEER 8
`define PTAC_TX_DTPH 9
`define PTAC_RX_DSTEER 8
`define PTAC_RX_HSTEER 9
`define PTAC_RX_PSTEER 10
`define PTAC_RX_DTPH 11
`define PTAC_RX_PTPH 12
`define PTAC_DC2_DIS 4
`define PTAC_GEN_RSND 0
`define PTAC_RSND_CNT_RST 2'h3
// ==========================================================
// tag values
`define PTAC_TAG_MSG 8'h00
`define PTAC_TAG_NOHINT 8'h00
`define PTAC_TAG_V1OFF 8'h00
`define PTAC_TAG_TXWB 8'h02
`define PTAC_TAG_RXWB 8'h04
`define PTAC_TAG_DATA 8'h06
`define PTAC_TAG_MSI 8'h1E
`define PTAC_TAG_TXDESC 8'h18
`define PTAC_TAG_RXDESC 8'h1C
`endif

// ===== shared/ptac_pkg.sv
// ptac_pkg: types shared by the tag allocator and its slot timers.
// assumes ptac_cfg.svh supplies all numeric constants.
package ptac_pkg;
   // ==========================================================
   // write and message request sources
   typedef enum logic [2:0] {
      SRC_TXWB,
      SRC_RXWB,
      SRC_RXHDR,
      SRC_RXPAY,
      SRC_MSI,
      SRC_MSG
   } ptac_src_e;
   // ==========================================================
   // outstanding read slot states
   typedef enum logic [1:0] {
      SL_IDLE,
      SL_WAIT,
      SL_DUE
   } ptac_slot_e;
endpackage : ptac_pkg

// ===== sim/ptac_rc_model.sv
// ptac_rc_model: root complex answering reads with completions.
// assumes each read grant stands for one read sent on the link.
`timescale 1ns/100ps
module ptac_rc_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // reads leaving the device
   input wire logic rdTagValid,
   input wire logic [7:0] rdTag,
   // behaviour chosen by the bench
   input wire logic answer,
   input wire logic [3:0] perReq,
   input wire logic [7:0] gap,
   // completions
   output logic cplValid,
   output logic [7:0] cplTag
);
   // ====================
   // pending reads, answered in order, gap idle cycles between completions
   logic [7:0] pend[$];
   int waitCnt;
   int sent;
   always @(posedge mclk) begin
      cplValid <= 1'b0;
      // idle tag lines flip so a stale tag never looks valid
      cplTag <= ~cplTag;
      if (rst) begin
         pend.delete();
         waitCnt = 0;
         sent = 0;
         cplTag <= 8'h5A;
      end else begin
         if (rdTagValid && answer) pend.push_back(rdTag);
         if (pend.size() != 0 && waitCnt < gap) waitCnt++;
         else if (pend.size() != 0) begin
            waitCnt = 0;
            cplValid <= 1'b1;
            cplTag <= pend[0];
            sent++;
            if (sent >= perReq) begin
               sent = 0;
               void'(pend.pop_front());
            end
         end
      end
   end
endmodule : ptac_rc_model

// ===== sim/ptac_tag_cto_sva.sv
// ptac_tag_cto_sva: port assertions for the tag allocator.
// assumes the bind below and the register map of ptac_cfg.svh.
`timescale 1ns/100ps
`include "ptac_cfg.svh"
module ptac_tag_cto_sva import ptac_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   // requests and grants
   input wire logic rdReq,
   input wire logic [2:0] rdClient,
   input wire logic [7:0] rdTag,
   input wire logic rdTagValid,
   input wire logic wrReq,
   input wire ptac_src_e wrSrc,
   input wire logic [7:0] wrTag,
   input wire logic wrTagValid,
   // timeout reactions
   input wire logic resendValid,
   input wire logic ctoErr
);
   // ====================
   // shadow of steering mode and timeout disable
   logic [2:0] ctrlQ;
   logic [1:0] offCnt;
   wire ctrlWr = regWr && regAddr == `PTAC_REG_CTRL;
   wire dc2Wr = regWr && regAddr == `PTAC_REG_DEVCTL2;
   wire dc2Off = regWdata[`PTAC_DC2_DIS];
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrlQ <= `PTAC_CTRL_RST;
         offCnt <= 2'h0;
      end else begin
         if (ctrlWr) ctrlQ <= regWdata[2:0];
         // saturates three cycles after the disable write
         if (dc2Wr && !dc2Off) offCnt <= 2'h0;
         else if ((dc2Wr || offCnt != 2'h0) && offCnt != 2'h3)
            offCnt <= offCnt + 2'h1;
      end
   end
   function automatic logic [7:0] tmap(input logic [2:0] c);
      if (c == 3'h6) return `PTAC_TAG_TXDESC;
      if (c == 3'h7) return `PTAC_TAG_RXDESC;
      return {5'h00, c};
   endfunction : tmap
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ====================
   // assertions
   a_rd_tag_map: assert property (
      rdTagValid |-> $past(rdReq) && rdTag == tmap($past(rdClient)))
      else $error("bad read grant");
   a_msg_zero: assert property (
      wrReq && wrSrc == SRC_MSG |=> wrTagValid && wrTag == 8'h00)
      else $error("message tag not zero");
   a_wr_answer: assert property (wrTagValid == $past(wrReq))
      else $error("write grant timing");
   a_fixed_msi: assert property (
      wrReq && ctrlQ[0] && wrSrc == SRC_MSI |=> wrTag == 8'h1E)
      else $error("fixed msi tag wrong");
   a_v1_msi: assert property (
      wrReq && ctrlQ[1:0] == 2'h2 && wrSrc == SRC_MSI |=> wrTag == 8'h00)
      else $error("msi tag not no-hint");
   a_legacy_flag: assert property (
      wrTagValid && $past(ctrlQ) == 3'h0 && wrTag[0] |-> wrTag[7:4] == 4'h0)
      else $error("legacy steered tag high bits");
   a_cto_off: assert property (
      offCnt == 2'h3 |-> !resendValid && !ctoErr)
      else $error("timeout event while disabled");
   a_reg_answer: assert property (
      regRdata != 32'h0 |-> $past(regRd) && $past(regAddr) <= 8'h14)
      else $error("read data without read");
endmodule : ptac_tag_cto_sva
bind ptac_tag_cto ptac_tag_cto_sva i_ptac_tag_cto_sva (.mclk, .rst,
   .regAddr, .regWdata, .regWr, .regRd, .regRdata, .rdReq, .rdClient,
   .rdTag, .rdTagValid, .wrReq, .wrSrc, .wrTag, .wrTagValid,
   .resendValid, .ctoErr);

// ===== sim/tb_top.sv
// tb_top: directed bench for tag allocation and completion timeout.
// assumes the design, ptac_cfg.svh and the root complex model.
`timescale 1ns/100ps
module tb_top import ptac_pkg::*; ;
   // ====================
   // signals
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0, regRd = 1'b0;
   logic lnkClk = 1'b0, lnkRun = 1'b0, lnkCfgWr = 1'b0;
   logic [4:0] lnkDevNum = 5'h00;
   logic nvmResendEn = 1'b1, rdReq = 1'b0, wrReq = 1'b0, answer = 1'b0;
   logic [2:0] rdClient = 3'h0;
   logic [3:0] rdCplCnt = 4'h1, perReq = 4'h1;
   logic [7:0] gap = 8'h00, e, lastRes, lastErr;
   ptac_src_e wrSrc = SRC_TXWB;
   logic [31:0] regRdata;
   logic [7:0] rdFree, rdTag, wrTag, cplTag, resendTag, ctoErrTag;
   logic rdTagValid, wrTagValid, cplValid, resendValid, ctoErr;
   int errCount = 0, totalChecks = 0, nRes = 0, nErr = 0, nCpl = 0;
   int r0, e0, c0, i, m;
   always #5 mclk = ~mclk;
   // link clock only runs inside a configuration frame
   always begin
      #40;
      if (lnkRun) lnkClk = ~lnkClk;
   end
   always @(posedge mclk) begin
      if (resendValid) begin
         nRes++;
         lastRes = resendTag;
      end
      if (ctoErr) begin
         nErr++;
         lastErr = ctoErrTag;
      end
      if (cplValid) nCpl++;
   end
   ptac_tag_cto #(.TICK_CYC(1)) i_ptac_tag_cto (.mclk, .rst, .regAddr,
      .regWdata, .regWr, .regRd, .regRdata, .lnkClk, .lnkCfgWr,
      .lnkDevNum, .nvmResendEn, .rdReq, .rdClient, .rdCplCnt, .rdFree,
      .rdTag, .rdTagValid, .wrReq, .wrSrc, .wrTag, .wrTagValid, .cplValid,
      .cplTag, .resendValid, .resendTag, .ctoErr, .ctoErrTag);
   ptac_rc_model i_ptac_rc_model (.mclk, .rst, .rdTagValid, .rdTag,
      .answer, .perReq, .gap, .cplValid, .cplTag);
   // ====================
   // tasks
   task chk(input string nm, input logic [31:0] seen, exp);
      totalChecks++;
      if (seen !== exp) begin
         errCount++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task summarize;
      if (errCount == 0 && totalChecks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic waitN(ref int c, input int t, input int lim);
      int k;
      for (k = 0; k < lim && c < t; k++) @(posedge mclk);
      if (c < t) begin
         chk("wait", c, t);
         summarize();
      end
   endtask : waitN
   task wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wreg
   task rchk(input logic [7:0] a, input logic [31:0] x);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 chk("reg", regRdata, x);
   endtask : rchk
   task wset(input logic [31:0] c, tx, rx);
      wreg(8'h00, c);
      wreg(8'h04, tx);
      wreg(8'h08, rx);
   endtask : wset
   task wtag(input ptac_src_e s, input logic [7:0] x);
      @(posedge mclk);
      wrReq <= 1'b1;
      wrSrc <= s;
      @(posedge mclk);
      wrReq <= 1'b0;
      #1 chk("wrTag", {wrTagValid, wrTag}, {1'b1, x});
   endtask : wtag
   task rtag(input logic [2:0] c, input logic [3:0] n, input logic [8:0] x);
      @(posedge mclk);
      rdReq <= 1'b1;
      rdClient <= c;
      rdCplCnt <= n;
      @(posedge mclk);
      rdReq <= 1'b0;
      #1 chk("rdTag", {rdTagValid, rdTag}, x);
   endtask : rtag
   // ====================
   // sequence
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      rchk(8'h00, 32'h1);
      rchk(8'h0C, 32'h0);
      rchk(8'h10, 32'h7);
      wreg(8'h40, 32'hFFFFFFFF);
      rchk(8'h40, 32'h0);
      @(posedge mclk);
      lnkDevNum <= 5'h0B;
      lnkCfgWr <= 1'b1;
      lnkRun = 1'b1;
      repeat (40) @(posedge mclk);
      lnkRun = 1'b0;
      lnkCfgWr <= 1'b0;
      lnkDevNum <= 5'h14;
      rchk(8'h14, 32'h0000000B);
      wset(32'h1, 32'h1A3, 32'h35E);
      wtag(SRC_TXWB, 8'h02);
      wtag(SRC_RXWB, 8'h04);
      wtag(SRC_RXHDR, 8'h06);
      wtag(SRC_RXPAY, 8'h06);
      wtag(SRC_MSI, 8'h1E);
      wtag(SRC_MSG, 8'h00);
      wset(32'h0, 32'h1A3, 32'h35E);
      wtag(SRC_TXWB, 8'h07);
      wtag(SRC_RXWB, 8'h0D);
      wtag(SRC_RXHDR, 8'h0D);
      wtag(SRC_RXPAY, 8'h06);
      wtag(SRC_MSI, 8'h1E);
      wtag(SRC_MSG, 8'h00);
      wset(32'h2, 32'h1A3, 32'h35E);
      wtag(SRC_TXWB, 8'hA3);
      wtag(SRC_RXHDR, 8'h5E);
      wtag(SRC_RXPAY, 8'h00);
      wtag(SRC_MSI, 8'h00);
      wtag(SRC_MSG, 8'h00);
      wset(32'h4, 32'h2A3, 32'h105E);
      wtag(SRC_TXWB, 8'hA3);
      wtag(SRC_RXPAY, 8'h5E);
      wtag(SRC_RXWB, 8'h04);
      // all eight slots, timer frozen, then released by timeout
      wreg(8'h0C, 32'h11);
      wreg(8'h10, 32'h6);
      for (i = 0; i < 8; i++) begin
         e = i < 6 ? i[7:0] : (i == 6 ? 8'h18 : 8'h1C);
         rtag(i[2:0], 4'h1, {1'b1, e});
      end
      rtag(3'h2, 4'h1, 9'h01C);
      r0 = nRes;
      e0 = nErr;
      repeat (300) @(posedge mclk);
      #1 chk("quiet", nRes + nErr, r0 + e0);
      chk("rdFree", rdFree, 8'h00);
      wreg(8'h0C, 32'h01);
      waitN(nErr, e0 + 8, 600);
      repeat (2) @(posedge mclk);
      #1 chk("rdFree", rdFree, 8'hFF);
      chk("noResend", nRes, r0);
      rchk(8'h14, 32'h0800000B);
      for (m = 1; m < 4; m++) begin
         wreg(8'h10, m * 2 + 1);
         r0 = nRes;
         e0 = nErr;
         rtag(3'h6, 4'h1, 9'h118);
         for (i = 0; i < 200 && nRes == r0; i++) @(posedge mclk);
         chk("firstResend", i > 95 && i < 110, 1'b1);
         waitN(nErr, e0 + 1, 1000);
         chk("resends", nRes - r0, m);
         chk("resendTag", lastRes, 8'h18);
         chk("errTag", lastErr, 8'h18);
      end
      answer <= 1'b1;
      perReq <= 4'h3;
      gap <= 8'h14;
      c0 = nCpl;
      e0 = nErr;
      rtag(3'h7, 4'h3, 9'h11C);
      waitN(nCpl, c0 + 2, 200);
      repeat (2) @(posedge mclk);
      #1 chk("slotHeld", rdFree[7], 1'b0);
      waitN(nCpl, c0 + 3, 200);
      repeat (3) @(posedge mclk);
      #1 chk("slotFreed", rdFree[7], 1'b1);
      chk("noTimeout", nErr, e0);
      // second reset with the strap low: resend enable follows it
      @(posedge mclk);
      nvmResendEn <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      rchk(8'h10, 32'h6);
      rchk(8'h0C, 32'h0);
      summarize();
   end
endmodule : tb_top
